//--- external_interrupt_config.sv
// Top of the external interrupt configuration block with its two SFRs.
// Assumes a simple SFR bus: one-cycle write strobe, combinational read data.
//
// Notes on behaviour
// - Polarity bit clear means active low; set means active high.
// - Trigger-type bit one selects edge mode; zero selects level mode.
// - Second interrupt polarity is config bit 7; one is active high.
// - First interrupt polarity is config bit 3; zero is active low.
// - Bits 6:4 pick the port 0 pin for the second interrupt.
// - Bits 2:0 pick the port 0 pin for the first interrupt.
// - Pin selection ignores the crossbar allocation of that pin.
// - Pins are only observed, never driven or altered.
// - Pending flags appear at timer control bits 1 and 3.
// - Active edge sets pending; vectoring to the routine clears it.
// - Level mode pending flag follows the qualified input.
// - Priority register at 0xF7 on all pages; upper nibble reads zero.
// - Config register at 0xE4 on page 0, reset value 0x01.
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module external_interrupt_config #(
  parameter int PINS = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [PINS-1:0] i_port0_pins,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_irq_a_trigger_type,
  input wire logic i_irq_b_trigger_type,
  input wire logic i_irq_a_vector_ack,
  input wire logic i_irq_b_vector_ack,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic o_irq_a_pending,
  output logic o_irq_b_pending,
  output logic [7:0] o_timer_control_pending,
  output logic [3:0] o_priority_select
);
  logic [7:0] ext_irq_config_reg;
  logic [7:0] ext_irq_config_next;
  logic [7:0] ext_priority_two_reg;
  logic [7:0] ext_priority_two_next;
  logic [PINS-1:0] pins_sync;
  logic hit_config;
  logic hit_priority;
  logic irq_a_pend;
  logic irq_b_pend;
  ext_irq_pkg::trig_mode_type mode_a;
  ext_irq_pkg::trig_mode_type mode_b;

  // Synchronisers are input-only taps on the pins; nothing drives them.
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_sync
      pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_port0_pins[g]),
        .o_pin(pins_sync[g])
      );
    end
  endgenerate

  assign hit_config = (i_sfr_addr == `SFR_ADDR_EXT_IRQ_CONFIG) &&
                      (i_sfr_page == `SFR_PAGE_EXT_IRQ_CONFIG);
  assign hit_priority = (i_sfr_addr == `SFR_ADDR_EXT_PRIORITY_TWO);

  assign ext_irq_config_next = (i_sfr_wr && hit_config) ? i_sfr_wdata : ext_irq_config_reg;
  assign ext_priority_two_next = (i_sfr_wr && hit_priority) ?
                                 (i_sfr_wdata & `EXT_PRIORITY_TWO_WMASK) :
                                 ext_priority_two_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_irq_config_reg <= `EXT_IRQ_CONFIG_RESET;
      ext_priority_two_reg <= `EXT_PRIORITY_TWO_RESET;
    end else begin
      ext_irq_config_reg <= ext_irq_config_next;
      ext_priority_two_reg <= ext_priority_two_next;
    end
  end

  assign o_sfr_hit = hit_config | hit_priority;
  assign o_sfr_rdata = hit_config ? ext_irq_config_reg :
                       (hit_priority ? ext_priority_two_reg : 8'h00);
  assign o_priority_select = ext_priority_two_reg[3:0];

  assign mode_a = i_irq_a_trigger_type ? ext_irq_pkg::trig_edge : ext_irq_pkg::trig_level;
  assign mode_b = i_irq_b_trigger_type ? ext_irq_pkg::trig_edge : ext_irq_pkg::trig_level;

  irq_channel #(.PINS(PINS)) u_chan_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins_sync(pins_sync),
    .i_pin_select(ext_irq_config_reg[`IRQ_A_SEL_HI:`IRQ_A_SEL_LO]),
    .i_polarity(ext_irq_config_reg[`IRQ_A_POLARITY_BIT]),
    .i_trigger_type(mode_a),
    .i_vector_ack(i_irq_a_vector_ack),
    .o_pending(irq_a_pend),
    .o_active()
  );

  irq_channel #(.PINS(PINS)) u_chan_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins_sync(pins_sync),
    .i_pin_select(ext_irq_config_reg[`IRQ_B_SEL_HI:`IRQ_B_SEL_LO]),
    .i_polarity(ext_irq_config_reg[`IRQ_B_POLARITY_BIT]),
    .i_trigger_type(mode_b),
    .i_vector_ack(i_irq_b_vector_ack),
    .o_pending(irq_b_pend),
    .o_active()
  );

  // Level requests are expected to stay until recognised and to drop before return.
  assign o_irq_a_pending = irq_a_pend;
  assign o_irq_b_pending = irq_b_pend;

  always_comb begin
    o_timer_control_pending = 8'h00;
    o_timer_control_pending[`TIMER_CONTROL_REG_IRQ_A_PENDING_BIT] = irq_a_pend;
    o_timer_control_pending[`TIMER_CONTROL_REG_IRQ_B_PENDING_BIT] = irq_b_pend;
  end
endmodule // external_interrupt_config

//--- ext_irq_defs.svh
// Constants for the external interrupt configuration block.
// Assumes it is included by bare name from each design file that needs it.
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

`define SFR_ADDR_EXT_IRQ_CONFIG 8'hE4
`define SFR_PAGE_EXT_IRQ_CONFIG 8'h00
`define SFR_ADDR_EXT_PRIORITY_TWO 8'hF7
`define EXT_IRQ_CONFIG_RESET 8'h01
`define EXT_PRIORITY_TWO_RESET 8'h00
`define EXT_PRIORITY_TWO_WMASK 8'h0F
`define IRQ_B_POLARITY_BIT 7
`define IRQ_B_SEL_HI 6
`define IRQ_B_SEL_LO 4
`define IRQ_A_POLARITY_BIT 3
`define IRQ_A_SEL_HI 2
`define IRQ_A_SEL_LO 0
`define TIMER_CONTROL_REG_IRQ_A_PENDING_BIT 1
`define TIMER_CONTROL_REG_IRQ_B_PENDING_BIT 3
`define SYNC_STAGES 2

`endif

//--- ext_irq_pkg.sv
// Types shared by the external interrupt configuration block.
// Assumes nothing of its surroundings.
package ext_irq_pkg;
  typedef logic [2:0] pin_sel_type;
  typedef enum logic {
    trig_level,
    trig_edge
  } trig_mode_type;
endpackage

//--- pin_sync.sv
// Two-flop synchroniser for one port 0 pin.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_pin
);
  logic meta_reg;
  logic stable_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      stable_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      stable_reg <= meta_reg;
    end
  end

  assign o_pin = stable_reg;
endmodule // pin_sync

//--- irq_channel.sv
// One external interrupt channel: pin select, polarity, edge or level, pending flag.
// Assumes the port pins arrive already synchronised to i_clk.
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module irq_channel #(
  parameter int PINS = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [PINS-1:0] i_pins_sync,
  input wire ext_irq_pkg::pin_sel_type i_pin_select,
  input wire logic i_polarity,
  input wire ext_irq_pkg::trig_mode_type i_trigger_type,
  input wire logic i_vector_ack,
  output logic o_pending,
  output logic o_active
);
  logic level_raw;
  logic active_now;
  logic active_prev_reg;
  logic edge_seen;
  logic edge_flag_reg;
  logic edge_flag_next;

  assign level_raw = i_pins_sync[i_pin_select];
  // Polarity clear means the request is active low.
  assign active_now = i_polarity ? level_raw : ~level_raw;
  assign edge_seen = active_now & ~active_prev_reg;
  // An edge in the acknowledge cycle survives the clear.
  assign edge_flag_next = edge_seen ? 1'b1 : (i_vector_ack ? 1'b0 : edge_flag_reg);

  // The previous level keeps tracking through reset, so no false edge follows reset.
  always_ff @(posedge i_clk) begin
    active_prev_reg <= active_now;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      edge_flag_reg <= 1'b0;
    end else begin
      edge_flag_reg <= (i_trigger_type == ext_irq_pkg::trig_edge) ? edge_flag_next : 1'b0;
    end
  end

  // Level mode follows the qualified input directly.
  assign o_pending = (i_trigger_type == ext_irq_pkg::trig_edge) ? edge_flag_reg
                                                                 : active_now;
  assign o_active = active_now;
endmodule // irq_channel

//--- ext_pin_source.sv
// Far-side model: external circuits driving port 0 request levels.
// Assumes the bench sets the wanted levels.
`timescale 1ns/1ps
module ext_pin_source (
  input wire logic i_clk,
  input wire logic [7:0] i_level,
  output logic [7:0] o_pins
);
  initial o_pins = 8'h00;
  // Levels hold until the bench moves them, after the request is seen.
  always @(posedge i_clk) o_pins <= #1 i_level;
endmodule // ext_pin_source

//--- ext_irq_props.sv
// Port checks for the external interrupt block.
// Assumes a bind to external_interrupt_config.
`timescale 1ns/1ps
module ext_irq_props #(
  parameter int PINS = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [PINS-1:0] i_port0_pins,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_irq_a_trigger_type,
  input wire logic i_irq_a_vector_ack,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  input wire logic o_irq_a_pending,
  input wire logic o_irq_b_pending,
  input wire logic [7:0] o_timer_control_pending,
  input wire logic [3:0] o_priority_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] cfg_reg;
  logic [PINS-1:0] pins_reg;
  logic [2:0] quiet_reg;
  wire cfg_sel = i_sfr_addr == 8'hE4 && i_sfr_page == 8'h00;
  wire act = i_port0_pins[cfg_reg[2:0]] == cfg_reg[3];
  wire calm = !i_rst && !i_sfr_wr && i_port0_pins == pins_reg;
  // Counts cycles with no pin change and no write, so the synchroniser has settled.
  always_ff @(posedge i_clk) begin
    cfg_reg <= i_rst ? 8'h01 : (cfg_sel && i_sfr_wr) ? i_sfr_wdata : cfg_reg;
    pins_reg <= i_port0_pins;
    quiet_reg <= !calm ? 3'h0 : quiet_reg + 3'(quiet_reg != 3'h7);
  end
  AST_PEND_MAP: assert property (
    o_timer_control_pending == {4'h0, o_irq_b_pending, 1'b0, o_irq_a_pending, 1'b0})
    else $error("pending bits misplaced");
  AST_CFG_READ: assert property (cfg_sel |-> o_sfr_hit && o_sfr_rdata == cfg_reg)
    else $error("config read wrong");
  AST_PAGE_ONLY: assert property (
    i_sfr_addr == 8'hE4 && i_sfr_page != 8'h00 |-> !o_sfr_hit)
    else $error("config seen off page");
  AST_PRIO_READ: assert property (
    i_sfr_addr == 8'hF7 |-> o_sfr_rdata == {4'h0, o_priority_select})
    else $error("priority read wrong");
  AST_PRIO_WRITE: assert property (
    i_sfr_wr && i_sfr_addr == 8'hF7 |=> o_priority_select == $past(i_sfr_wdata[3:0]))
    else $error("priority write lost");
  AST_LEVEL_A: assert property (
    !i_irq_a_trigger_type && calm && quiet_reg > 3'h2 |-> o_irq_a_pending == act)
    else $error("level pending wrong");
  AST_EDGE_SET: assert property (
    i_irq_a_trigger_type && act && !$past(act) && quiet_reg > 3'h2 && !i_sfr_wr
    ##1 (i_irq_a_trigger_type && !i_irq_a_vector_ack && !i_sfr_wr)[*4]
    |-> o_irq_a_pending)
    else $error("edge not flagged");
  AST_ACK_CLEAR: assert property (
    i_irq_a_trigger_type && i_irq_a_vector_ack && calm && quiet_reg > 3'h2
    |=> !o_irq_a_pending || !i_irq_a_trigger_type)
    else $error("ack did not clear");
  cover property (i_irq_a_vector_ack && o_irq_a_pending);
  cover property (i_sfr_wr && cfg_sel);
  cover property (o_irq_b_pending && !i_irq_a_trigger_type);
endmodule // ext_irq_props
bind external_interrupt_config ext_irq_props #(.PINS(PINS)) u_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_port0_pins(i_port0_pins),
  .i_sfr_addr(i_sfr_addr),
  .i_sfr_page(i_sfr_page),
  .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata),
  .i_irq_a_trigger_type(i_irq_a_trigger_type),
  .i_irq_a_vector_ack(i_irq_a_vector_ack),
  .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_hit(o_sfr_hit),
  .o_irq_a_pending(o_irq_a_pending),
  .o_irq_b_pending(o_irq_b_pending),
  .o_timer_control_pending(o_timer_control_pending),
  .o_priority_select(o_priority_select)
);

//--- test_external_interrupt_config.sv
// Bench for external_interrupt_config: registers, level and edge requests.
// Assumes the design, pin source and checker are compiled first.
`timescale 1ns/1ps
module test_external_interrupt_config;
  logic i_clk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_irq_a_trigger_type = 1'b0;
  logic i_irq_b_trigger_type = 1'b0, i_irq_a_vector_ack = 1'b0, i_irq_b_vector_ack = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_page = 8'h00, i_sfr_wdata = 8'h00, lvl = 8'h00;
  logic [7:0] i_port0_pins, o_sfr_rdata, o_timer_control_pending;
  logic [3:0] o_priority_select;
  logic o_sfr_hit, o_irq_a_pending, o_irq_b_pending;
  int miscompares = 0, tests_run = 0;
  always #2.5 i_clk = ~i_clk;
  ext_pin_source u_src (.i_clk(i_clk), .i_level(lvl), .o_pins(i_port0_pins));
  external_interrupt_config u_dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_port0_pins(i_port0_pins),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_page(i_sfr_page),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .i_irq_a_trigger_type(i_irq_a_trigger_type),
    .i_irq_b_trigger_type(i_irq_b_trigger_type),
    .i_irq_a_vector_ack(i_irq_a_vector_ack),
    .i_irq_b_vector_ack(i_irq_b_vector_ack),
    .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit),
    .o_irq_a_pending(o_irq_a_pending),
    .o_irq_b_pending(o_irq_b_pending),
    .o_timer_control_pending(o_timer_control_pending),
    .o_priority_select(o_priority_select)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    {i_sfr_addr, i_sfr_page, i_sfr_wdata, i_sfr_wr} = {a, p, d, 1'b1};
    cyc(1);
    i_sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
    {i_sfr_addr, i_sfr_page} = {a, p};
    #1;
    chk(o_sfr_rdata, e);
    chk({7'h00, o_sfr_hit}, {7'h00, (a == 8'hE4 && p == 8'h00) || a == 8'hF7});
    cyc(1);
  endtask
  task automatic t_regs;
    rd(8'hE4, 8'h00, 8'h01);
    rd(8'hF7, 8'h00, 8'h00);
    sw(8'hF7, 8'h03, 8'hFF);
    rd(8'hF7, 8'h09, 8'h0F);
    chk({4'h0, o_priority_select}, 8'h0F);
    sw(8'hE4, 8'h01, 8'h55);
    rd(8'hE4, 8'h00, 8'h01);
    rd(8'h42, 8'h00, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_level;
    for (int i = 0; i < 8; i++) begin
      sw(8'hE4, 8'h00, {1'b1, i[2:0], 1'b1, i[2:0]});
      lvl = 8'h01 << i;
      cyc(5);
      chk(o_timer_control_pending, 8'h0A);
      lvl = ~lvl;
      cyc(5);
      chk(o_timer_control_pending, 8'h00);
    end
    sw(8'hE4, 8'h00, 8'h32);
    lvl = 8'hF3;
    cyc(5);
    chk(o_timer_control_pending, 8'h0A);
    $display("t_level done");
  endtask
  task automatic t_edge;
    sw(8'hE4, 8'h00, 8'h0A);
    {lvl, i_irq_a_trigger_type, i_irq_b_trigger_type} = {8'h00, 2'b11};
    cyc(5);
    lvl = 8'h05;
    cyc(5);
    chk({6'h00, o_irq_b_pending, o_irq_a_pending}, 8'h03);
    lvl = 8'h01;
    cyc(5);
    chk({6'h00, o_irq_b_pending, o_irq_a_pending}, 8'h03);
    {i_irq_a_vector_ack, i_irq_b_vector_ack} = 2'b11;
    cyc(1);
    {i_irq_a_vector_ack, i_irq_b_vector_ack} = 2'b00;
    cyc(2);
    chk({6'h00, o_irq_b_pending, o_irq_a_pending}, 8'h00);
    $display("t_edge done");
  endtask
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(4);
    i_rst = 1'b0;
    t_regs;
    t_level;
    t_edge;
    complete_run;
  end
  initial begin
    #5000;
    miscompares++;
    complete_run;
  end
endmodule // test_external_interrupt_config
